// [src/bit_map_pkg.sv]
// Overview of operation
// - Sixteen independent mapping entries, selected by index one to sixteen.
// - An entry copies any length up to and including 1024 bits.
// - Entry holds source register, source bit, target register, target bit, length.
// - Bit copies run only after the standard area mapping of the cycle finished.
// - Entries run in index order, so a later entry wins on overlap.
// - Configured entries are stored at once but used only after a restart.
// - Changed mapping entries take effect only when the module restarts; script and terminal port settings change at once.
// - A restart holds fieldbus traffic and releases it when reinitialised.
// - Writing 0x0002 to restore_defaults_command restores defaults and re-enables terminal.
// - Factory reset needs confirmation value 36, then defaults and a restart.
// - Deleting an entry clears it so that it copies nothing.
// - The module runs cyclically, distributing data once per cycle.
// - Interfaces exchange data through their own buffers, not tied to the cycle.
// - A cycle normally ends below 1 ms, though it may exceed 5 ms.
// - Script enable toggles on and off; script port toggles serial and terminal.
`default_nettype none
package bit_map_pkg;
  localparam int unsigned ENTRY_COUNT = 16;
  localparam int unsigned LEN_W = 11;
  localparam logic [10:0] LEN_MAX = 11'h400;
  localparam logic [15:0] DEFAULT_REG = 16'h0001;
  localparam logic [3:0] DEFAULT_BIT = 4'h0;
  localparam logic [10:0] DEFAULT_LEN = 11'h000;
  localparam logic [15:0] CMD_REG_ADDR = 16'h0001;
  localparam logic [15:0] CMD_RESTORE = 16'h0002;
  localparam logic [15:0] CMD_REG_RESET = 16'h0000;
  localparam logic [7:0] FACTORY_CONFIRM = 8'h24;
  localparam logic [7:0] RESTART_CYCLES = 8'h10;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CYCLE_NORMAL_US = 1000;
  localparam int unsigned CYCLE_LONG_US = 5000;
  localparam int unsigned CYCLE_NORMAL_CLKS = CYCLE_NORMAL_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CYCLE_LONG_CLKS = CYCLE_LONG_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CYC_CNT_W = 20;

  typedef struct packed {
    logic [15:0] src_reg;
    logic [3:0]  src_bit;
    logic [15:0] dst_reg;
    logic [3:0]  dst_bit;
    logic [10:0] length;
  } map_entry_t;

  localparam map_entry_t DEFAULT_ENTRY = '{DEFAULT_REG, DEFAULT_BIT, DEFAULT_REG,
                                           DEFAULT_BIT, DEFAULT_LEN};

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_RD_SRC,
    ST_RD_DST,
    ST_WR_DST,
    ST_NEXT,
    ST_RESTART
  } engine_state_t;
endpackage : bit_map_pkg
`default_nettype wire

// [src/extended_bit_mapping_engine.sv]
`default_nettype none
module extended_bit_mapping_engine #(
  parameter int unsigned CYCLE_NORMAL_CLKS = bit_map_pkg::CYCLE_NORMAL_CLKS,
  parameter int unsigned CYCLE_LONG_CLKS   = bit_map_pkg::CYCLE_LONG_CLKS
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Module cycle sequencing.
  input  wire logic        std_map_done,
  output logic             bit_map_done,
  output logic             bit_map_busy,
  output logic             cycle_slow,
  output logic             cycle_overrun,
  // Shared register space access.
  output logic [15:0]      mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [15:0]      mem_wdata,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        mem_ack,
  // Entry configuration from the terminal or serial register port.
  input  wire logic        cfg_wr,
  input  wire logic        cfg_delete,
  input  wire logic [4:0]  cfg_index,
  input  wire logic [15:0] cfg_src_reg,
  input  wire logic [3:0]  cfg_src_bit,
  input  wire logic [15:0] cfg_dst_reg,
  input  wire logic [3:0]  cfg_dst_bit,
  input  wire logic [10:0] cfg_length,
  output logic             cfg_reject,
  // Serial register port access to the command register.
  input  wire logic        sreg_wr,
  input  wire logic        sreg_rd,
  input  wire logic [15:0] sreg_addr,
  input  wire logic [15:0] sreg_wdata,
  output logic [15:0]      sreg_rdata,
  output logic             sreg_rvalid,
  // Module commands.
  input  wire logic        restart_req,
  input  wire logic        factory_req,
  input  wire logic [7:0]  factory_code,
  input  wire logic        term_port_disable,
  input  wire logic        script_toggle_enable,
  input  wire logic        script_toggle_port,
  // Module status.
  output logic             fieldbus_hold,
  output logic             config_terminal_port_en,
  output logic             script_enable,
  output logic             script_port_terminal
);

  typedef struct packed {
    bit_map_pkg::engine_state_t              st;
    logic [3:0]                              idx;
    bit_map_pkg::map_entry_t [15:0]          stored;
    bit_map_pkg::map_entry_t [15:0]          active;
    logic [10:0]                             remain;
    logic [15:0]                             sa;
    logic [3:0]                              sb;
    logic [15:0]                             da;
    logic [3:0]                              db;
    logic                                    bitv;
    logic [7:0]                              rst_cnt;
    logic [bit_map_pkg::CYC_CNT_W-1:0]       cyc_cnt;
    logic                                    cyc_run;
    logic [15:0]                             cmd_reg;
    logic [15:0]                             mem_addr;
    logic                                    mem_rd;
    logic                                    mem_wr;
    logic [15:0]                             mem_wdata;
    logic                                    map_done;
    logic                                    map_busy;
    logic                                    slow;
    logic                                    overrun;
    logic                                    cfg_reject;
    logic [15:0]                             sreg_rdata;
    logic                                    sreg_rvalid;
    logic                                    fb_hold;
    logic                                    term_en;
    logic                                    script_en;
    logic                                    script_term;
  } state_t;

  state_t cur;
  state_t next_cur;
  localparam int unsigned      CNT_W      = bit_map_pkg::CYC_CNT_W;
  localparam logic [CNT_W-1:0] NORMAL_LIM = CNT_W'(CYCLE_NORMAL_CLKS);
  localparam logic [CNT_W-1:0] LONG_LIM   = CNT_W'(CYCLE_LONG_CLKS);

  always_comb
  begin
    bit_map_pkg::map_entry_t ent;
    logic [15:0]             merged;
    ent = bit_map_pkg::DEFAULT_ENTRY;
    merged = 16'h0000;
    next_cur = cur;
    next_cur.map_done = 1'b0;
    next_cur.sreg_rvalid = 1'b0;
    next_cur.cfg_reject = 1'b0;

    if (cfg_wr)
    begin
      if (cfg_index == 5'h00 || cfg_index > 5'h10)
      begin
        next_cur.cfg_reject = 1'b1;
      end
      else if (cfg_delete)
      begin
        next_cur.stored[4'(cfg_index - 5'h01)] = bit_map_pkg::DEFAULT_ENTRY;
      end
      else if (cfg_length > bit_map_pkg::LEN_MAX)
      begin
        next_cur.cfg_reject = 1'b1;
      end
      else
      begin
        next_cur.stored[4'(cfg_index - 5'h01)] = '{cfg_src_reg, cfg_src_bit, cfg_dst_reg,
                                                   cfg_dst_bit, cfg_length};
      end
    end

    next_cur.script_en = cur.script_en ^ script_toggle_enable;
    next_cur.script_term = cur.script_term ^ script_toggle_port;
    next_cur.term_en = cur.term_en & ~term_port_disable;
    if (sreg_rd)
    begin
      next_cur.sreg_rvalid = 1'b1;
      next_cur.sreg_rdata = (sreg_addr == bit_map_pkg::CMD_REG_ADDR) ? cur.cmd_reg : 16'h0000;
    end

    if (sreg_wr && sreg_addr == bit_map_pkg::CMD_REG_ADDR)
    begin
      next_cur.cmd_reg = sreg_wdata;
      if (sreg_wdata == bit_map_pkg::CMD_RESTORE)
      begin
        next_cur.stored = {16{bit_map_pkg::DEFAULT_ENTRY}};
        next_cur.term_en = 1'b1;
        next_cur.script_en = 1'b0;
        next_cur.script_term = 1'b0;
      end
    end

    if (cur.cyc_run)
    begin
      if (cur.cyc_cnt != {bit_map_pkg::CYC_CNT_W{1'b1}})
      begin
        next_cur.cyc_cnt = cur.cyc_cnt + 1'b1;
      end
      if (cur.cyc_cnt >= NORMAL_LIM)
      begin
        next_cur.slow = 1'b1;
      end
      if (cur.cyc_cnt >= LONG_LIM)
      begin
        next_cur.overrun = 1'b1;
      end
    end

    unique case (cur.st)
      bit_map_pkg::ST_IDLE:
      begin
        if (std_map_done)
        begin
          next_cur.st = bit_map_pkg::ST_LOAD;
          next_cur.idx = 4'h0;
          next_cur.map_busy = 1'b1;
          next_cur.cyc_run = 1'b1;
          next_cur.cyc_cnt = '0;
          next_cur.slow = 1'b0;
          next_cur.overrun = 1'b0;
        end
      end
      bit_map_pkg::ST_LOAD:
      begin
        ent = cur.active[cur.idx];
        if (ent.length == bit_map_pkg::DEFAULT_LEN)
        begin
          next_cur.st = bit_map_pkg::ST_NEXT;
        end
        else
        begin
          next_cur.sa = ent.src_reg;
          next_cur.sb = ent.src_bit;
          next_cur.da = ent.dst_reg;
          next_cur.db = ent.dst_bit;
          next_cur.remain = ent.length;
          next_cur.mem_addr = ent.src_reg;
          next_cur.mem_rd = 1'b1;
          next_cur.st = bit_map_pkg::ST_RD_SRC;
        end
      end
      bit_map_pkg::ST_RD_SRC:
      begin
        if (mem_ack)
        begin
          next_cur.bitv = mem_rdata[cur.sb];
          next_cur.mem_addr = cur.da;
          next_cur.st = bit_map_pkg::ST_RD_DST;
        end
      end
      bit_map_pkg::ST_RD_DST:
      begin
        if (mem_ack)
        begin
          merged = mem_rdata;
          merged[cur.db] = cur.bitv;
          next_cur.mem_wdata = merged;
          next_cur.mem_rd = 1'b0;
          next_cur.mem_wr = 1'b1;
          next_cur.st = bit_map_pkg::ST_WR_DST;
        end
      end
      bit_map_pkg::ST_WR_DST:
      begin
        if (mem_ack)
        begin
          next_cur.sb = cur.sb + 4'h1;
          next_cur.db = cur.db + 4'h1;
          next_cur.sa = (cur.sb == 4'hF) ? cur.sa + 16'h0001 : cur.sa;
          next_cur.da = (cur.db == 4'hF) ? cur.da + 16'h0001 : cur.da;
          next_cur.remain = cur.remain - 11'h001;
          next_cur.mem_wr = 1'b0;
          if (cur.remain == 11'h001)
          begin
            next_cur.st = bit_map_pkg::ST_NEXT;
          end
          else
          begin
            next_cur.mem_addr = (cur.sb == 4'hF) ? cur.sa + 16'h0001 : cur.sa;
            next_cur.mem_rd = 1'b1;
            next_cur.st = bit_map_pkg::ST_RD_SRC;
          end
        end
      end
      bit_map_pkg::ST_NEXT:
      begin
        if (cur.idx == 4'hF)
        begin
          next_cur.st = bit_map_pkg::ST_IDLE;
          next_cur.map_busy = 1'b0;
          next_cur.map_done = 1'b1;
          next_cur.cyc_run = 1'b0;
        end
        else
        begin
          next_cur.idx = cur.idx + 4'h1;
          next_cur.st = bit_map_pkg::ST_LOAD;
        end
      end
      bit_map_pkg::ST_RESTART:
      begin
        if (cur.rst_cnt == 8'h00)
        begin
          next_cur.fb_hold = 1'b0;
          next_cur.st = bit_map_pkg::ST_IDLE;
        end
        else
        begin
          next_cur.rst_cnt = cur.rst_cnt - 8'h01;
        end
      end
    endcase

    if (factory_req && factory_code == bit_map_pkg::FACTORY_CONFIRM)
    begin
      next_cur.stored = {16{bit_map_pkg::DEFAULT_ENTRY}};
      next_cur.term_en = 1'b1;
      next_cur.script_en = 1'b0;
      next_cur.script_term = 1'b0;
      next_cur.cmd_reg = bit_map_pkg::CMD_REG_RESET;
    end

    if (restart_req || (factory_req && factory_code == bit_map_pkg::FACTORY_CONFIRM))
    begin
      next_cur.active = next_cur.stored;
      next_cur.st = bit_map_pkg::ST_RESTART;
      next_cur.rst_cnt = bit_map_pkg::RESTART_CYCLES;
      next_cur.fb_hold = 1'b1;
      next_cur.mem_rd = 1'b0;
      next_cur.mem_wr = 1'b0;
      next_cur.map_busy = 1'b0;
      next_cur.map_done = 1'b0;
      next_cur.cyc_run = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cur <= '0;
      cur.st <= bit_map_pkg::ST_IDLE;
      cur.stored <= {16{bit_map_pkg::DEFAULT_ENTRY}};
      cur.active <= {16{bit_map_pkg::DEFAULT_ENTRY}};
      cur.term_en <= 1'b1;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign bit_map_done = cur.map_done;
  assign bit_map_busy = cur.map_busy;
  assign cycle_slow = cur.slow;
  assign cycle_overrun = cur.overrun;
  assign mem_addr = cur.mem_addr;
  assign mem_rd = cur.mem_rd;
  assign mem_wr = cur.mem_wr;
  assign mem_wdata = cur.mem_wdata;
  assign cfg_reject = cur.cfg_reject;
  assign sreg_rdata = cur.sreg_rdata;
  assign sreg_rvalid = cur.sreg_rvalid;
  assign fieldbus_hold = cur.fb_hold;
  assign config_terminal_port_en = cur.term_en;
  assign script_enable = cur.script_en;
  assign script_port_terminal = cur.script_term;

endmodule : extended_bit_mapping_engine
`default_nettype wire

// [tb/ebm_chk.sv]
`default_nettype none
module ebm_chk (
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        rst,
  // Cycle and memory side.
  input wire logic        std_map_done,
  input wire logic        bit_map_done,
  input wire logic        bit_map_busy,
  input wire logic        cycle_slow,
  input wire logic        cycle_overrun,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [15:0] mem_wdata,
  input wire logic        mem_ack,
  // Configuration and commands.
  input wire logic        cfg_wr,
  input wire logic [4:0]  cfg_index,
  input wire logic        cfg_reject,
  input wire logic        sreg_rd,
  input wire logic [15:0] sreg_addr,
  input wire logic [15:0] sreg_rdata,
  input wire logic        sreg_rvalid,
  input wire logic        restart_req,
  input wire logic        factory_req,
  input wire logic        fieldbus_hold
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [7:0] hold_cnt;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst) hold_cnt <= 8'h00;
    else hold_cnt <= fieldbus_hold ? hold_cnt + 8'h01 : 8'h00;
  logic cmd;
  assign cmd = restart_req | factory_req;
  a_start_busy: assert property (std_map_done && !bit_map_busy && !fieldbus_hold && !cmd
    |=> bit_map_busy) else $error("cycle start missed");
  a_done_end: assert property ($rose(bit_map_done) |-> $past(bit_map_busy) && !bit_map_busy)
    else $error("done without busy end");
  a_quiet_idle: assert property (!bit_map_busy |-> !mem_rd && !mem_wr)
    else $error("access while idle");
  a_rd_wr_excl: assert property (!(mem_rd && mem_wr)) else $error("read and write together");
  a_req_held: assert property ((mem_rd || mem_wr) && !mem_ack && !cmd |=>
    $stable({mem_rd, mem_wr, mem_addr, mem_wdata})) else $error("request dropped");
  a_hold_len: assert property ($fell(fieldbus_hold) |-> hold_cnt == 8'h11)
    else $error("hold length wrong");
  a_restart_hold: assert property (restart_req |=> fieldbus_hold) else $error("no hold");
  a_read_answer: assert property (sreg_rd |=> sreg_rvalid) else $error("no read answer");
  a_other_zero: assert property (sreg_rd && sreg_addr != 16'h0001 |=> sreg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_bad_index: assert property (cfg_wr && (cfg_index == 5'h00 || cfg_index > 5'h10) && !cmd
    |=> cfg_reject) else $error("bad index accepted");
  a_slow_first: assert property (cycle_overrun |-> cycle_slow) else $error("overrun not slow");
  cover property (bit_map_done);
  cover property (mem_wr && mem_ack);
  cover property ($fell(fieldbus_hold));
endmodule : ebm_chk
bind extended_bit_mapping_engine ebm_chk u_chk (.sys_clk, .rst, .std_map_done, .bit_map_done,
  .bit_map_busy, .cycle_slow, .cycle_overrun, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_ack,
  .cfg_wr, .cfg_index, .cfg_reject, .sreg_rd, .sreg_addr, .sreg_rdata, .sreg_rvalid,
  .restart_req, .factory_req, .fieldbus_hold);
`default_nettype wire

// [tb/extended_bit_mapping_engine_tb.sv]
`default_nettype none
module extended_bit_mapping_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus.
  logic sys_clk = '0, rst = 1'h1, std_map_done = '0, mem_ack = '0, cfg_wr = '0, cfg_delete = '0;
  logic sreg_wr = '0, sreg_rd = '0, restart_req = '0, factory_req = '0, term_port_disable = '0;
  logic        script_toggle_enable = '0, script_toggle_port = '0;
  logic [4:0]  cfg_index = '0;
  logic [3:0]  cfg_src_bit = '0, cfg_dst_bit = '0;
  logic [10:0] cfg_length = '0;
  logic [15:0] cfg_src_reg = '0, cfg_dst_reg = '0, sreg_addr = '0, sreg_wdata = '0;
  logic [7:0]  factory_code = '0;
  // Observed.
  logic bit_map_done, bit_map_busy, cycle_slow, cycle_overrun, mem_rd, mem_wr, cfg_reject;
  logic sreg_rvalid, fieldbus_hold, config_terminal_port_en, script_enable, script_port_terminal;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, sreg_rdata;
  logic [15:0] mem [16];
  int          n_mismatch = 0, cmp_count = 0;
  int          n;
  extended_bit_mapping_engine #(.CYCLE_NORMAL_CLKS(20), .CYCLE_LONG_CLKS(60)) u_dut (.*);
  always #10 sys_clk = ~sys_clk;
  // Shared register space answering one cycle after a request, or two cycles when it follows an answer.
  assign mem_rdata = mem[mem_addr[3:0]];
  always @(negedge sys_clk) mem_ack <= (mem_rd | mem_wr) & ~mem_ack;
  always @(posedge sys_clk) if (mem_ack && mem_wr) mem[mem_addr[3:0]] <= mem_wdata;
  task automatic tk(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : tk
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc();
    std_map_done = 1'h1;
    tk(1);
    std_map_done = 1'h0;
    for (n = 1; n < 20000 && bit_map_done !== 1'h1; n++) tk(1);
    chk(bit_map_done, 1'h1);
  endtask : cyc
  task automatic cfg(input logic [4:0] i, input logic [15:0] s, d, input logic [3:0] sb, db,
                     input logic [10:0] l, input logic del, rej);
    {cfg_index, cfg_src_reg, cfg_dst_reg, cfg_src_bit, cfg_dst_bit} = {i, s, d, sb, db};
    cfg_length = l;
    cfg_delete = del;
    cfg_wr = 1'h1;
    tk(1);
    cfg_wr = 1'h0;
    chk(cfg_reject, rej);
    tk(1);
  endtask : cfg
  task automatic hold(input logic [15:0] exp);
    int k = 0;
    tk(1);
    restart_req = 1'h0;
    factory_req = 1'h0;
    for (k = 0; k < 100 && fieldbus_hold === 1'h1; k++) tk(1);
    chk(16'(k), exp);
    tk(1);
  endtask : hold
  task automatic swr(input logic [15:0] d);
    {sreg_addr, sreg_wdata, sreg_wr} = {16'h0001, d, 1'h1};
    tk(1);
    sreg_wr = 1'h0;
    tk(1);
  endtask : swr
  task automatic srd(input logic [15:0] a, exp);
    {sreg_addr, sreg_rd} = {a, 1'h1};
    tk(1);
    sreg_rd = 1'h0;
    chk(sreg_rvalid, 1'h1);
    chk(sreg_rdata, exp);
    tk(1);
  endtask : srd
  task automatic t_default();
    for (int k = 0; k < 16; k++) mem[k] = {4{k[3:0]}};
    tk(4);
    rst = 1'h0;
    chk(config_terminal_port_en, 1'h1);
    chk({bit_map_busy, fieldbus_hold, script_enable, script_port_terminal}, 4'h0);
    cyc();
    chk(n > 31 && n < 37, 1'h1);
    chk({cycle_slow, cycle_overrun}, 2'h2);
    for (int k = 0; k < 16; k++) chk(mem[k], {4{k[3:0]}});
  endtask : t_default
  task automatic t_apply();
    {mem[2], mem[3], mem[5], mem[6]} = {16'h4000, 16'h0001, 16'h0000, 16'h0001};
    cfg(5'h01, 16'h0002, 16'h0005, 4'hE, 4'hF, 11'h003, 1'h0, 1'h0);
    cfg(5'h02, 16'h0002, 16'h0006, 4'h0, 4'h1, 11'h001, 1'h0, 1'h0);
    cyc();
    chk(mem[5], 16'h0000);
    restart_req = 1'h1;
    hold(16'h0011);
    cyc();
    chk(mem[5], 16'h8000);
    chk(mem[6], 16'h0000);
  endtask : t_apply
  task automatic t_limits();
    cfg(5'h00, 16'h0002, 16'h0005, 4'h0, 4'h0, 11'h001, 1'h0, 1'h1);
    cfg(5'h11, 16'h0002, 16'h0005, 4'h0, 4'h0, 11'h001, 1'h0, 1'h1);
    cfg(5'h03, 16'h0002, 16'h0005, 4'h0, 4'h0, 11'h401, 1'h0, 1'h1);
    cfg(5'h02, 16'h0002, 16'h0006, 4'h0, 4'h1, 11'h001, 1'h1, 1'h0);
    cfg(5'h10, 16'h0007, 16'h0007, 4'h0, 4'h0, 11'h400, 1'h0, 1'h0);
    mem[6] = 16'h0001;
    restart_req = 1'h1;
    hold(16'h0011);
    cyc();
    chk(cycle_overrun, 1'h1);
    chk(mem[6], 16'h0002);
    chk(mem[5], 16'h8000);
  endtask : t_limits
  task automatic t_serial();
    {script_toggle_enable, script_toggle_port, term_port_disable} = 3'h7;
    tk(1);
    {script_toggle_enable, script_toggle_port, term_port_disable} = 3'h0;
    tk(1);
    chk({script_enable, script_port_terminal, config_terminal_port_en}, 3'h6);
    swr(16'h0002);
    chk({script_enable, script_port_terminal, config_terminal_port_en}, 3'h1);
    srd(16'h0001, 16'h0002);
    srd(16'h0003, 16'h0000);
    mem[5] = 16'h0000;
    restart_req = 1'h1;
    hold(16'h0011);
    cyc();
    chk(mem[5], 16'h0000);
  endtask : t_serial
  task automatic t_factory();
    swr(16'h0005);
    script_toggle_enable = 1'h1;
    tk(1);
    script_toggle_enable = 1'h0;
    {factory_code, factory_req} = {8'h23, 1'h1};
    hold(16'h0000);
    chk(script_enable, 1'h1);
    srd(16'h0001, 16'h0005);
    {factory_code, factory_req} = {8'h24, 1'h1};
    hold(16'h0011);
    chk({script_enable, config_terminal_port_en}, 2'h1);
    srd(16'h0001, 16'h0000);
  endtask : t_factory
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  initial
  begin
    #2000000;
    n_mismatch++;
    conclude();
  end
  initial
  begin
    t_default();
    t_apply();
    t_limits();
    t_serial();
    t_factory();
    conclude();
  end
endmodule : extended_bit_mapping_engine_tb
`default_nettype wire
